// ---- verilog/smm_host.sv ----
// Purpose: Host end that frames commands on the serial link.
// Assumes: User holds request fields while req_valid is high.
// Notes:   Link clock is ref_clk divided by six.
`timescale 1ns/1ns
`default_nettype none
module smm_host
    import smm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    smm_link_if.host         link,
    input  wire logic        req_valid,
    input  wire logic [7:0]  req_op,
    input  wire logic [18:0] req_addr,
    input  wire logic [8:0]  req_len,
    input  wire logic        req_mode3,
    input  wire logic [7:0]  wr_data,
    input  wire logic        hold_req,
    input  wire logic        wp_level_n,
    output logic             busy,
    output logic             done,
    output logic             wr_take,
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             asleep
);

    // ========================================================
    // State
    typedef struct packed {
        smm_host_st_e       st;
        logic [1:0]         half_cnt;
        logic [2:0]         bit_i;
        logic [1:0]         addr_left;
        logic [8:0]         data_left;
        logic               in_data;
        logic [7:0]         tx;
        logic [7:0]         rx;
        logic [7:0]         op;
        logic [23:0]        addr24;
        logic [WAIT_W-1:0]  wait_cnt;
        logic               mode3;
        logic               so_meta;
        logic               so_sync;
        logic               cs_n;
        logic               sck;
        logic               si;
        logic               hold_n;
        logic               wp_n;
        logic               busy;
        logic               done;
        logic               wr_take;
        logic [7:0]         rd_data;
        logic               rd_valid;
        logic               asleep;
    } smm_host_s;

    smm_host_s h;
    smm_host_s next_h;
    logic      tick;
    logic [7:0] rxb;

    always_comb begin
        next_h          = h;
        next_h.done     = 1'b0;
        next_h.wr_take  = 1'b0;
        next_h.rd_valid = 1'b0;
        next_h.so_meta  = link.so_line;
        next_h.so_sync  = h.so_meta;
        next_h.wp_n     = wp_level_n;
        tick = (h.half_cnt == SCK_HALF_CYC - 2'h1);
        rxb  = {h.rx[6:0], h.so_sync};
        next_h.half_cnt = tick ? 2'h0 : h.half_cnt + 2'h1;
        // Hold moves only inside the shift phase and never falls on an
        // edge that moves the link clock, so the device sees it settled.
        next_h.hold_n = (h.st != H_SHIFT) ? 1'b1 :
                        (tick && h.hold_n) ? 1'b1 : ~hold_req;
        unique case (h.st)
            H_IDLE: begin
                next_h.half_cnt = 2'h0;
                if (req_valid) begin
                    if (h.asleep && req_op != WAKE_CMD) begin
                        next_h.done = 1'b1;
                    end else begin
                        next_h.st        = H_START;
                        next_h.busy      = 1'b1;
                        next_h.op        = req_op;
                        next_h.mode3     = req_mode3;
                        next_h.sck       = req_mode3;
                        next_h.addr24    = {5'h00, req_addr};
                        next_h.addr_left =
                            (req_op == DATA_READ_CMD ||
                             req_op == DATA_WRITE_CMD) ?
                            ADDR_BYTES : 2'h0;
                        next_h.data_left = req_len;
                        next_h.in_data   = 1'b0;
                        next_h.tx        = req_op;
                        next_h.si        = req_op[7];
                        next_h.bit_i     = 3'h0;
                    end
                end
            end
            H_START: begin
                if (tick) begin
                    next_h.cs_n = 1'b0;
                    next_h.st   = H_LEAD;
                end
            end
            H_LEAD: begin
                if (tick) begin
                    next_h.sck = 1'b0;
                    next_h.st  = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (!h.hold_n) begin
                    next_h.half_cnt = h.half_cnt;
                end else if (tick && !h.sck) begin
                    next_h.sck = 1'b1;
                end else if (tick) begin
                    next_h.rx    = rxb;
                    next_h.bit_i = h.bit_i + 3'h1;
                    next_h.sck   = 1'b0;
                    next_h.tx    = {h.tx[6:0], 1'b0};
                    next_h.si    = h.tx[6];
                    if (h.bit_i == 3'h7) begin
                        if (h.in_data && smm_op_reads(h.op)) begin
                            next_h.rd_data  = rxb;
                            next_h.rd_valid = 1'b1;
                        end
                        if (h.addr_left != 2'h0) begin
                            next_h.tx        = h.addr24[23:16];
                            next_h.addr24    = {h.addr24[15:0], 8'h00};
                            next_h.addr_left = h.addr_left - 2'h1;
                        end else if (h.data_left != 9'h0) begin
                            next_h.in_data   = 1'b1;
                            next_h.data_left = h.data_left - 9'h1;
                            next_h.tx        = 8'h00;
                            if (smm_op_writes(h.op)) begin
                                next_h.tx      = wr_data;
                                next_h.wr_take = 1'b1;
                            end
                        end else begin
                            // Frame closes on a byte boundary.
                            next_h.st  = H_END;
                            next_h.sck = h.mode3;
                        end
                        next_h.si = next_h.tx[7];
                    end
                end
            end
            H_END: begin
                if (tick) begin
                    next_h.cs_n = 1'b1;
                    next_h.st   = H_GAP;
                end
            end
            H_GAP: begin
                if (tick) begin
                    next_h.st   = H_IDLE;
                    next_h.busy = 1'b0;
                    next_h.done = 1'b1;
                    if (h.op == SLEEP_CMD) begin
                        next_h.asleep   = 1'b1;
                        next_h.st       = H_WAIT;
                        next_h.busy     = 1'b1;
                        next_h.done     = 1'b0;
                        next_h.wait_cnt = WAIT_W'(SLEEP_ENTRY_CYC);
                    end else if (h.op == WAKE_CMD) begin
                        next_h.asleep   = 1'b0;
                        next_h.st       = H_WAIT;
                        next_h.busy     = 1'b1;
                        next_h.done     = 1'b0;
                        next_h.wait_cnt =
                            WAIT_W'(WAKE_RECOVERY_CYC);
                    end
                end
            end
            H_WAIT: begin
                next_h.wait_cnt = h.wait_cnt - 1'b1;
                if (h.wait_cnt == '0) begin
                    next_h.st   = H_IDLE;
                    next_h.busy = 1'b0;
                    next_h.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            h <= '{st: H_IDLE, half_cnt: 2'h0, bit_i: 3'h0,
                   addr_left: 2'h0, data_left: 9'h0,
                   in_data: 1'b0, tx: 8'h00, rx: 8'h00,
                   op: 8'h00, addr24: 24'h0,
                   wait_cnt: '0, mode3: 1'b0,
                   so_meta: 1'b0, so_sync: 1'b0,
                   cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                   hold_n: 1'b1, wp_n: 1'b1, busy: 1'b0,
                   done: 1'b0, wr_take: 1'b0, rd_data: 8'h00,
                   rd_valid: 1'b0, asleep: 1'b0};
        end else begin
            h <= next_h;
        end
    end

    assign link.cs_n   = h.cs_n;
    assign link.sck    = h.sck;
    assign link.si     = h.si;
    assign link.hold_n = h.hold_n;
    assign link.wp_n   = h.wp_n;
    assign busy        = h.busy;
    assign done        = h.done;
    assign wr_take     = h.wr_take;
    assign rd_data     = h.rd_data;
    assign rd_valid    = h.rd_valid;
    assign asleep      = h.asleep;

endmodule
`default_nettype wire

// ---- include/smm_pkg.sv ----
// Purpose: Shared constants and types for the serial memory command port.
// Assumes: Host and device meet through smm_link_if.
// Notes:   Link is an SPI-style serial port, modes 0 and 3.
package smm_pkg;

    // ========================================================
    // Opcodes
    localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
    localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
    localparam logic [7:0] DATA_READ_CMD         = 8'h03;
    localparam logic [7:0] DATA_WRITE_CMD        = 8'h02;
    localparam logic [7:0] SLEEP_CMD             = 8'hb9;
    localparam logic [7:0] WAKE_CMD              = 8'hab;

    // ========================================================
    // Status layout and array geometry
    localparam int         WRITE_DISABLE_BIT = 7;
    localparam int         PROTECT_HIGH_BIT  = 3;
    localparam int         PROTECT_LOW_BIT   = 2;
    localparam int         WRITE_LATCH_BIT   = 1;
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam int         ADDR_W            = 19;
    localparam int         MEM_DEPTH         = 524288;
    localparam logic [1:0] ADDR_BYTES        = 2'h3;

    // ========================================================
    // Timing at the 10 ns reference clock
    localparam int CLK_PERIOD_NS          = 10;
    localparam int SLEEP_ENTRY_DELAY_NS   = 1000;
    localparam int WAKE_RECOVERY_DELAY_NS = 1000;
    localparam int SLEEP_ENTRY_CYC =
        (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_RECOVERY_CYC =
        (WAKE_RECOVERY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         WAIT_W       = 8;
    localparam logic [1:0] SCK_HALF_CYC = 2'h3;

    // ========================================================
    // Types
    typedef enum logic [2:0] {
        PH_OPCODE, PH_ADDR, PH_READ, PH_WRITE,
        PH_STAT_RD, PH_STAT_WR, PH_IGNORE
    } smm_phase_e;

    typedef enum logic [2:0] {
        H_IDLE, H_START, H_LEAD, H_SHIFT, H_END, H_GAP, H_WAIT
    } smm_host_st_e;

    // True where the protect pair covers the address.
    function automatic logic smm_protected(input logic [1:0] bp,
                                           input logic [18:0] a);
        logic r;
        r = 1'b0;
        case (bp)
            2'b01:   r = (a[18:17] == 2'b11);
            2'b10:   r = a[18];
            2'b11:   r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic smm_op_reads(input logic [7:0] op);
        return (op == DATA_READ_CMD) || (op == STATUS_READ_CMD);
    endfunction

    function automatic logic smm_op_writes(input logic [7:0] op);
        return (op == DATA_WRITE_CMD) || (op == STATUS_WRITE_CMD);
    endfunction

endpackage

// ---- include/smm_link_if.sv ----
// Purpose: Serial link between host and memory device.
// Assumes: so_line resolves the released output to zero.
// Notes:   Host drives every pin except the serial output.
`timescale 1ns/1ns
`default_nettype none
interface smm_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic hold_n;
    logic wp_n;
    logic so_line;

    assign so_line = so_oe & so;

    modport dev (input cs_n, sck, si, hold_n, wp_n,
                 output so, so_oe);
    modport host (output cs_n, sck, si, hold_n, wp_n,
                  input so_line);
endinterface
`default_nettype wire

// ---- verilog/smm_device.sv ----
// Purpose: Memory device end of the serial command port.
// Assumes: Link clock runs only inside frames; host keeps
//          its own obligations on byte counts and wake timing.
// Notes:   Frame state clears while select is high.
`timescale 1ns/1ns
`default_nettype none
module smm_device
    import smm_pkg::*;
(
    smm_link_if.dev         link,
    input  wire logic       reset_n,
    output logic            mode3,
    output logic            asleep,
    output logic [7:0]      status_byte
);

    // ========================================================
    // State
    typedef struct packed {
        logic [2:0]  bit_cnt;
        logic [7:0]  rx;
        logic [7:0]  tx;
        smm_phase_e  phase;
        logic        is_read;
        logic [1:0]  addr_left;
        logic [18:0] addr;
    } smm_frame_s;

    typedef struct packed {
        logic write_enable_latch;
        logic asleep;
        logic wp_meta;
        logic wp_sync;
    } smm_power_s;

    typedef struct packed {
        logic so;
        logic so_oe;
    } smm_out_s;

    smm_frame_s fr;
    smm_frame_s next_fr;
    smm_power_s pw;
    smm_power_s next_pw;
    smm_out_s   ob;
    smm_out_s   next_ob;
    logic       frame_rst;
    logic [7:0] byte_in;
    logic [7:0] status_now;
    logic [7:0] next_nv;
    logic       mem_we;
    logic [7:0] mem_wdata;
    logic [1:0] bp;
    logic [18:0] full_addr;

    // Non-volatile status bits hold their value over reset,
    // as a power cycle must not disturb them; the latch bit
    // of this copy is never used.
    logic [7:0] nv = STATUS_RESET;

    logic [7:0] mem [0:MEM_DEPTH-1];

    // Select high or power-up both abandon the frame.
    assign frame_rst = link.cs_n | ~reset_n;

    assign bp = {nv[PROTECT_HIGH_BIT], nv[PROTECT_LOW_BIT]};

    always_comb begin
        status_now = nv;
        status_now[WRITE_LATCH_BIT] = pw.write_enable_latch;
    end

    // ========================================================
    // Next-state logic on the rising edge
    always_comb begin
        next_fr   = fr;
        next_pw   = pw;
        next_nv   = nv;
        mem_we    = 1'b0;
        mem_wdata = 8'h00;
        byte_in   = {fr.rx[6:0], link.si};
        full_addr = {fr.addr[10:0], byte_in};
        next_pw.wp_meta = link.wp_n;
        next_pw.wp_sync = pw.wp_meta;
        if (link.hold_n) begin
            next_fr.rx      = byte_in;
            next_fr.bit_cnt = fr.bit_cnt + 3'h1;
            if (fr.bit_cnt == 3'h7) begin
                unique case (fr.phase)
                    PH_OPCODE: begin
                        next_fr.phase = PH_IGNORE;
                        if (pw.asleep) begin
                            if (byte_in == WAKE_CMD) begin
                                next_pw.asleep = 1'b0;
                            end
                        end else begin
                            case (byte_in)
                                SET_WRITE_LATCH_CMD: begin
                                    next_pw.write_enable_latch = 1'b1;
                                end
                                CLEAR_WRITE_LATCH_CMD: begin
                                    next_pw.write_enable_latch = 1'b0;
                                end
                                STATUS_READ_CMD: begin
                                    next_fr.phase = PH_STAT_RD;
                                    next_fr.tx    = status_now;
                                end
                                STATUS_WRITE_CMD: begin
                                    next_fr.phase = PH_STAT_WR;
                                end
                                DATA_READ_CMD: begin
                                    next_fr.phase     = PH_ADDR;
                                    next_fr.is_read   = 1'b1;
                                    next_fr.addr_left = ADDR_BYTES;
                                end
                                DATA_WRITE_CMD: begin
                                    next_fr.phase     = PH_ADDR;
                                    next_fr.is_read   = 1'b0;
                                    next_fr.addr_left = ADDR_BYTES;
                                end
                                SLEEP_CMD: begin
                                    next_pw.asleep = 1'b1;
                                end
                                default: begin
                                    next_fr.phase = PH_IGNORE;
                                end
                            endcase
                        end
                    end
                    PH_ADDR: begin
                        // Upper address bits fall off the top.
                        next_fr.addr      = full_addr;
                        next_fr.addr_left = fr.addr_left - 2'h1;
                        if (fr.addr_left == 2'h1) begin
                            if (fr.is_read) begin
                                next_fr.phase = PH_READ;
                                next_fr.tx    = mem[full_addr];
                                next_fr.addr  = full_addr + 19'h1;
                            end else begin
                                next_fr.phase = PH_WRITE;
                            end
                        end
                    end
                    PH_WRITE: begin
                        if (pw.write_enable_latch &&
                            !smm_protected(bp, fr.addr)) begin
                            mem_we    = 1'b1;
                            mem_wdata = byte_in;
                        end
                        next_fr.addr = fr.addr + 19'h1;
                    end
                    PH_READ: begin
                        next_fr.tx   = mem[fr.addr];
                        next_fr.addr = fr.addr + 19'h1;
                    end
                    PH_STAT_RD: begin
                        next_fr.tx = status_now;
                    end
                    PH_STAT_WR: begin
                        next_fr.phase = PH_IGNORE;
                        if (pw.write_enable_latch &&
                            (!nv[WRITE_DISABLE_BIT] ||
                             pw.wp_sync)) begin
                            next_nv = byte_in;
                        end
                    end
                    PH_IGNORE: begin
                        next_fr.phase = PH_IGNORE;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // Rising-edge registers
    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            fr <= '{bit_cnt: 3'h0, rx: 8'h00, tx: 8'h00,
                    phase: PH_OPCODE, is_read: 1'b0,
                    addr_left: 2'h0, addr: 19'h0};
        end else begin
            fr <= next_fr;
        end
    end

    always_ff @(posedge link.sck or negedge reset_n) begin
        if (!reset_n) begin
            // Power-up clears the latch and leaves sleep.
            pw <= '{write_enable_latch: 1'b0, asleep: 1'b0,
                    wp_meta: 1'b0, wp_sync: 1'b0};
        end else if (!link.cs_n) begin
            pw <= next_pw;
        end
    end

    // Bit 0 changes only through a permitted status write.
    always_ff @(posedge link.sck) begin
        if (!link.cs_n && reset_n) begin
            nv <= next_nv;
        end
    end

    always_ff @(posedge link.sck) begin
        if (mem_we && !link.cs_n) begin
            mem[fr.addr] <= mem_wdata;
        end
    end

    // ========================================================
    // Falling-edge output; nothing is driven before the first
    // rising edge because the phase is still the opcode.
    always_comb begin
        next_ob = ob;
        if (link.hold_n &&
            (fr.phase == PH_READ || fr.phase == PH_STAT_RD)) begin
            next_ob.so    = fr.tx[3'h7 - fr.bit_cnt];
            next_ob.so_oe = 1'b1;
        end
    end

    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            ob <= '{so: 1'b0, so_oe: 1'b0};
        end else begin
            ob <= next_ob;
        end
    end

    assign link.so    = ob.so;
    assign link.so_oe = ob.so_oe;

    // ========================================================
    // Mode capture at the select fall.
    always_ff @(negedge link.cs_n or negedge reset_n) begin
        if (!reset_n) begin
            mode3 <= 1'b0;
        end else begin
            mode3 <= link.sck;
        end
    end

    assign asleep      = pw.asleep;
    assign status_byte = status_now;

endmodule
`default_nettype wire

// ---- sim/smm_asserts.sv ----
// Purpose: Link checks for the serial memory command port.
// Assumes: ref_clk samples every link edge.
// Notes:   Bit count is kept per select-low period.
`timescale 1ns/1ns
`default_nettype none
module smm_asserts (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic hold_n
);
    // ==========================================================
    // Rising link edges counted since select fell.
    logic [11:0] rises;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) rises <= 12'h000;
        else if (cs_n) rises <= 12'h000;
        else if ($rose(sck) && hold_n) rises <= rises + 12'h001;
    end
    AST_SO_RELEASED: assert property (cs_n |-> !so_oe)
        else $error("Output driven while deselected.");
    AST_SO_ON_FALL: assert property (!cs_n && !$past(cs_n)
        && $changed(so) |-> $fell(sck)) else $error("Output moved.");
    AST_SI_SETTLED: assert property (!cs_n && $changed(si)
        |-> !$rose(sck)) else $error("Input moved at capture.");
    AST_WHOLE_BYTES: assert property ($rose(cs_n)
        |-> rises[2:0] == 3'h0) else $error("Partial byte.");
    AST_OE_AFTER_OP: assert property ($rose(so_oe)
        |-> rises >= 12'h008) else $error("Output before opcode.");
    AST_MODE_KEPT: assert property ($fell(cs_n)
        |-> $stable(sck) ##1 $stable(sck)) else $error("Clock moved.");
    AST_HOLD_IN_FRAME: assert property ($changed(hold_n)
        |-> !cs_n && !$past(cs_n)) else $error("Hold moved outside.");
    AST_SELECT_GAP: assert property ($rose(cs_n)
        |=> cs_n[*2]) else $error("Select gap too short.");
    cover property ($rose(so_oe));
    cover property ($fell(cs_n) && sck);
    cover property ($fell(hold_n));
endmodule
`default_nettype wire

// ---- sim/smm_bench.sv ----
// Purpose: Bench for host and device of the serial memory port.
// Assumes: Memory starts unknown, so only written bytes are read.
// Notes:   Link clock comes from the host divider.
`timescale 1ns/1ns
`default_nettype none
module smm_bench import smm_pkg::*;;
    logic ref_clk = 1'b0, reset_n = 1'b0, rv = 1'b0, m3 = 1'b0;
    logic hold = 1'b0, wpn = 1'b1, dm3, ds, wt, rdv, bz, dn, ha;
    logic [7:0] op = 8'h00, wd = 8'h00, rd, st, wq[$], rq[$];
    logic [18:0] ad = 19'h0;
    logic [8:0] ln = 9'h0;
    int n_errors = 0, cmp_count = 0;
    smm_link_if link ();
    smm_host i_smm_host (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
        .req_valid(rv), .req_op(op), .req_addr(ad), .req_len(ln),
        .req_mode3(m3), .wr_data(wd), .hold_req(hold), .wp_level_n(wpn),
        .busy(bz), .done(dn), .wr_take(wt), .rd_data(rd), .rd_valid(rdv),
        .asleep(ha));
    smm_device i_smm_device (.link(link), .reset_n(reset_n), .mode3(dm3),
        .asleep(ds), .status_byte(st));
    smm_asserts i_smm_asserts (.ref_clk(ref_clk), .reset_n(reset_n),
        .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so(link.so),
        .so_oe(link.so_oe), .hold_n(link.hold_n));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        #1;
        if (rdv) rq.push_back(rd);
        if (wt) wq = wq[1:$];
        wd = (wq.size() != 0) ? wq[0] : 8'h00;
    end
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (e !== g) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic run(logic [7:0] o, logic [18:0] a, logic [8:0] n);
        int t = 0;
        op = o;
        ad = a;
        ln = n;
        rq = {};
        rv = 1'b1;
        @(posedge ref_clk) #1 rv = 1'b0;
        while (dn !== 1'b1 && t < 9000) @(posedge ref_clk) #1 t++;
        if (t == 9000) n_errors++;
        chk("busy at done", 8'h00, {7'h0, bz});
        @(posedge ref_clk) #1;
    endtask
    task automatic t_latch;
        chk("status reset", 8'h00, st);
        run(SET_WRITE_LATCH_CMD, 19'h0, 9'h0);
        chk("latch set", 8'h02, st);
        run(STATUS_READ_CMD, 19'h0, 9'h1);
        chk("status read", 8'h02, rq[0]);
        run(CLEAR_WRITE_LATCH_CMD, 19'h0, 9'h0);
        chk("latch clear", 8'h00, st);
        $display("test latch finished");
    endtask
    task automatic t_data;
        run(SET_WRITE_LATCH_CMD, 19'h0, 9'h0);
        wq = {8'ha5, 8'h3c};
        run(DATA_WRITE_CMD, 19'h7ffff, 9'h2);
        fork begin
            repeat (60) @(posedge ref_clk);
            #1 hold = 1'b1;
            repeat (12) @(posedge ref_clk);
            #1 hold = 1'b0;
        end join_none
        run(DATA_READ_CMD, 19'h7ffff, 9'h2);
        chk("top byte", 8'ha5, rq[0]);
        chk("wrap byte", 8'h3c, rq[1]);
        run(CLEAR_WRITE_LATCH_CMD, 19'h0, 9'h0);
        wq = {8'h00};
        run(DATA_WRITE_CMD, 19'h7ffff, 9'h1);
        run(DATA_READ_CMD, 19'h7ffff, 9'h1);
        chk("locked write", 8'ha5, rq[0]);
        $display("test data finished");
    endtask
    task automatic t_protect;
        run(SET_WRITE_LATCH_CMD, 19'h0, 9'h0);
        wq = {8'h8c};
        run(STATUS_WRITE_CMD, 19'h0, 9'h1);
        chk("status written", 8'h8e, st);
        wpn = 1'b0;
        wq = {8'h00};
        run(STATUS_WRITE_CMD, 19'h0, 9'h1);
        chk("status locked", 8'h8e, st);
        wq = {8'h77};
        run(DATA_WRITE_CMD, 19'h0, 9'h1);
        run(DATA_READ_CMD, 19'h0, 9'h1);
        chk("all protected", 8'h3c, rq[0]);
        wpn = 1'b1;
        wq = {8'h04};
        run(STATUS_WRITE_CMD, 19'h0, 9'h1);
        wq = {8'h11, 8'h55};
        run(DATA_WRITE_CMD, 19'h7ffff, 9'h2);
        run(DATA_READ_CMD, 19'h7ffff, 9'h2);
        chk("upper quarter", 8'ha5, rq[0]);
        chk("lower part", 8'h55, rq[1]);
        $display("test protect finished");
    endtask
    task automatic t_sleep;
        m3 = 1'b1;
        run(SLEEP_CMD, 19'h0, 9'h0);
        chk("asleep", 8'h01, {7'h0, ds});
        chk("mode three", 8'h01, {7'h0, dm3});
        chk("host asleep", 8'h01, {7'h0, ha});
        run(STATUS_READ_CMD, 19'h0, 9'h1);
        chk("refused read", 8'h00, 8'(rq.size()));
        run(WAKE_CMD, 19'h0, 9'h0);
        chk("awake", 8'h00, {7'h0, ds});
        run(SET_WRITE_LATCH_CMD, 19'h0, 9'h0);
        run(SLEEP_CMD, 19'h0, 9'h0);
        reset_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        @(posedge ref_clk) #1;
        chk("power kept", 8'h04, st);
        chk("power woke", 8'h00, {7'h0, ds});
        $display("test sleep finished");
    endtask
    task automatic give_verdict;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        @(posedge ref_clk) #1;
        t_latch;
        t_data;
        t_protect;
        t_sleep;
        give_verdict;
    end
    initial begin
        #900000 n_errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
